// File: sbs_pkg.sv
/*
 * Shared constants and types for the burst access sequencer: host bus field
 * positions, memory command codes, burst size and default memory timing.
 * Assumes a 32-bit multiplexed host bus and a 32-bit memory data path.
 */
package sbs_pkg;

    // ------------------------------------------------------------------
    // Host bus fields
    // ------------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int ROW_W = 11;
    localparam int COL_W = 8;
    localparam int CMD_HI = 29;
    localparam int CMD_LO = 28;
    localparam int BANK_BIT = 21;
    localparam int ROW_HI = 20;
    localparam int ROW_LO = 10;
    localparam int COL_HI = 9;
    localparam int COL_LO = 2;
    localparam logic [1:0] ACCESS_CODE = 2'h0;

    // ------------------------------------------------------------------
    // Memory side
    // ------------------------------------------------------------------
    localparam int BURST_LEN = 8;
    localparam int AUTO_CLOSE_BIT = 10;
    localparam int RCD_CYCLES = 2;
    localparam int CAS_CYCLES = 2;
    localparam int OE_COPIES = 4;
    // Command codes as {cs_n, ras_n, cas_n, we_n}.
    localparam logic [3:0] SD_NOP = 4'h7;
    localparam logic [3:0] SD_ACTIVATE = 4'h3;
    localparam logic [3:0] SD_WRITE = 4'h4;
    localparam logic [3:0] SD_READ = 4'h5;
    localparam logic [3:0] SD_DESELECT = 4'hf;

    typedef enum logic [2:0] {
        SBS_IDLE,
        SBS_ACT,
        SBS_RCD,
        SBS_WRITE,
        SBS_READ_C,
        SBS_READ_W,
        SBS_READ
    } sbs_state_t;

endpackage : sbs_pkg

// File: sbs_pad_if.sv
/*
 * Bundle between the sequencer core and its pin register stage.
 * Assumes both ends run on the same memory clock.
 */
interface sbs_pad_if;
    timeunit 1ns;
    timeprecision 100ps;

    logic [3:0] cmd_n;
    logic [10:0] addr;
    logic bank;
    logic [31:0] wdata;
    logic drive;
    logic [31:0] rdata;

    modport core (
        output cmd_n,
        output addr,
        output bank,
        output wdata,
        output drive,
        input rdata
    );

    modport pad (
        input cmd_n,
        input addr,
        input bank,
        input wdata,
        input drive,
        output rdata
    );
endinterface : sbs_pad_if

// File: sbs_pin_regs.sv
/*
 * Pin register stage: every memory signal passes one flip-flop that sits
 * directly at the pad. Assumes the pad drivers are built from the enables.
 */
module sbs_pin_regs (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Core side
    sbs_pad_if.pad pad,
    // Memory pins
    output logic sd_cs_n_out,
    output logic sd_ras_n_out,
    output logic sd_cas_n_out,
    output logic sd_we_n_out,
    output logic [10:0] sd_a_out,
    output logic sd_ba_out,
    input wire logic [31:0] sd_dq_in,
    output logic [31:0] sd_dq_out,
    output logic [3:0] sd_dq_oe_out
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [3:0] next_oe;

    // ------------------------------------------------------------------
    // Pad registers
    // ------------------------------------------------------------------
    // One enable per byte lane keeps the fan-out of each copy at eight.
    always_comb begin
        next_oe = {sbs_pkg::OE_COPIES{pad.drive}};
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            {sd_cs_n_out, sd_ras_n_out, sd_cas_n_out, sd_we_n_out} <= sbs_pkg::SD_DESELECT;
            sd_a_out <= 11'h000;
            sd_ba_out <= 1'b0;
            sd_dq_out <= 32'h0000_0000;
            sd_dq_oe_out <= 4'h0;
            pad.rdata <= 32'h0000_0000;
        end else begin
            {sd_cs_n_out, sd_ras_n_out, sd_cas_n_out, sd_we_n_out} <= pad.cmd_n;
            sd_a_out <= pad.addr;
            sd_ba_out <= pad.bank;
            sd_dq_out <= pad.wdata;
            sd_dq_oe_out <= next_oe;
            pad.rdata <= sd_dq_in;
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    // The pins still hold their reset values at the first edge after release.
    oe_copies_a: assert property (!$past(rst_in) |->
        sd_dq_oe_out == {4{$past(pad.drive)}})
        else $error("Data enable copies differ from the core request.");
    cmd_pad_reg_a: assert property (!$past(rst_in) |->
        {sd_cs_n_out, sd_ras_n_out, sd_cas_n_out, sd_we_n_out} == $past(pad.cmd_n)
        && sd_dq_out == $past(pad.wdata))
        else $error("Memory pins are not one register after the core.");

endmodule : sbs_pin_regs

// File: sbs_burst_seq.sv
/*
 * Eight-word burst sequencer between a multiplexed host bus and a memory.
 * Assumes core_clk_in is the doubled host clock that also clocks the memory,
 * and that host_clk_in is the host clock level sampled on it.
 */
// Function
// - The core and memory run at twice the host clock rate, derived by doubling.
// - The sequencer issues the row activate with the row address for reads and writes.
// - After the row-to-column delay it issues the auto-closing write with the first of eight words.
// - After the row-to-column delay it issues the auto-closing read with the column address.
// - After the read latency it captures eight returned words and delivers them to the host.
// - Every memory signal is registered in a flip-flop directly at the pin.
// - The memory data enable is registered at the pins in four copies of eight bits each.
// - The location is latched while the phase select is low: bank bit 21, row 20:10, column 9:2.
// - Write words are captured every core clock and read words are put on the bus the same way.
module sbs_burst_seq #(
    parameter int RCD = sbs_pkg::RCD_CYCLES,
    parameter int CAS = sbs_pkg::CAS_CYCLES
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Host bus
    input wire logic host_clk_in,
    input wire logic data_addr_n_in,
    input wire logic host_wr_in,
    input wire logic [31:0] ad_in,
    output logic [31:0] ad_out,
    output logic ad_oe_out,
    // Memory pins
    output logic sd_cs_n_out,
    output logic sd_ras_n_out,
    output logic sd_cas_n_out,
    output logic sd_we_n_out,
    output logic [10:0] sd_a_out,
    output logic sd_ba_out,
    input wire logic [31:0] sd_dq_in,
    output logic [31:0] sd_dq_out,
    output logic [3:0] sd_dq_oe_out
);
    timeunit 1ns;
    timeprecision 100ps;

    sbs_pad_if pad_bus ();

    sbs_pkg::sbs_state_t state, next_state;
    logic [2:0] cnt, next_cnt;
    logic [2:0] beat, next_beat;
    logic dir_write, next_dir_write;
    logic [10:0] row, next_row;
    logic [7:0] col, next_col;
    logic bank, next_bank;
    logic [3:0] wcap, next_wcap;
    logic [31:0] wbuf [8];
    logic [31:0] next_wbuf [8];
    logic [31:0] next_ad;
    logic next_ad_oe;
    logic start;

    // ------------------------------------------------------------------
    // Burst sequencing
    // ------------------------------------------------------------------
    // Address phases are only taken in the first core cycle of a host
    // period, so one host cycle never starts two bursts.
    assign start = state == sbs_pkg::SBS_IDLE && !data_addr_n_in && host_clk_in
        && ad_in[sbs_pkg::CMD_HI:sbs_pkg::CMD_LO] == sbs_pkg::ACCESS_CODE;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_beat = beat;
        next_dir_write = dir_write;
        next_row = row;
        next_col = col;
        next_bank = bank;
        next_wcap = wcap;
        next_wbuf = wbuf;
        next_ad = ad_out;
        next_ad_oe = 1'b0;
        unique case (state)
            sbs_pkg::SBS_IDLE: begin
                if (start) begin
                    next_state = sbs_pkg::SBS_ACT;
                    next_dir_write = host_wr_in;
                    next_row = ad_in[sbs_pkg::ROW_HI:sbs_pkg::ROW_LO];
                    next_col = ad_in[sbs_pkg::COL_HI:sbs_pkg::COL_LO];
                    next_bank = ad_in[sbs_pkg::BANK_BIT];
                    next_wcap = 4'h0;
                end
            end
            sbs_pkg::SBS_ACT: begin
                next_state = sbs_pkg::SBS_RCD;
                next_cnt = 3'(RCD - 1);
            end
            sbs_pkg::SBS_RCD: begin
                next_beat = 3'h0;
                if (cnt <= 3'h1) begin
                    next_state = dir_write ? sbs_pkg::SBS_WRITE : sbs_pkg::SBS_READ_C;
                end else begin
                    next_cnt = cnt - 3'h1;
                end
            end
            sbs_pkg::SBS_WRITE: begin
                next_beat = beat + 3'h1;
                if (beat == 3'(sbs_pkg::BURST_LEN - 1)) begin
                    next_state = sbs_pkg::SBS_IDLE;
                end
            end
            sbs_pkg::SBS_READ_C: begin
                next_state = sbs_pkg::SBS_READ_W;
                next_cnt = 3'(CAS);
            end
            sbs_pkg::SBS_READ_W: begin
                next_beat = 3'h0;
                if (cnt == 3'h0) begin
                    next_state = sbs_pkg::SBS_READ;
                end else begin
                    next_cnt = cnt - 3'h1;
                end
            end
            sbs_pkg::SBS_READ: begin
                next_ad = pad_bus.rdata;
                next_ad_oe = 1'b1;
                next_beat = beat + 3'h1;
                if (beat == 3'(sbs_pkg::BURST_LEN - 1)) begin
                    next_state = sbs_pkg::SBS_IDLE;
                end
            end
        endcase
        // Write words arrive while the row opens; the buffer hides that gap.
        if (state != sbs_pkg::SBS_IDLE && dir_write && data_addr_n_in && host_wr_in
            && wcap != 4'(sbs_pkg::BURST_LEN)) begin
            next_wbuf[wcap[2:0]] = ad_in;
            next_wcap = wcap + 4'h1;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= sbs_pkg::SBS_IDLE;
            cnt <= 3'h0;
            beat <= 3'h0;
            dir_write <= 1'b0;
            row <= 11'h000;
            col <= 8'h00;
            bank <= 1'b0;
            wcap <= 4'h0;
            wbuf <= '{default: 32'h0000_0000};
            ad_out <= 32'h0000_0000;
            ad_oe_out <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            beat <= next_beat;
            dir_write <= next_dir_write;
            row <= next_row;
            col <= next_col;
            bank <= next_bank;
            wcap <= next_wcap;
            wbuf <= next_wbuf;
            ad_out <= next_ad;
            ad_oe_out <= next_ad_oe;
        end
    end

    // ------------------------------------------------------------------
    // Memory command decode
    // ------------------------------------------------------------------
    always_comb begin
        pad_bus.cmd_n = sbs_pkg::SD_NOP;
        pad_bus.addr = {3'h1 << 2, col};
        pad_bus.bank = bank;
        pad_bus.wdata = wbuf[beat];
        pad_bus.drive = state == sbs_pkg::SBS_WRITE;
        unique case (state)
            sbs_pkg::SBS_ACT: begin
                pad_bus.cmd_n = sbs_pkg::SD_ACTIVATE;
                pad_bus.addr = row;
            end
            sbs_pkg::SBS_WRITE: begin
                if (beat == 3'h0) begin
                    pad_bus.cmd_n = sbs_pkg::SD_WRITE;
                end
            end
            sbs_pkg::SBS_READ_C: begin
                pad_bus.cmd_n = sbs_pkg::SD_READ;
            end
            sbs_pkg::SBS_IDLE, sbs_pkg::SBS_RCD, sbs_pkg::SBS_READ_W, sbs_pkg::SBS_READ: begin
                pad_bus.cmd_n = sbs_pkg::SD_NOP;
            end
        endcase
    end

    sbs_pin_regs u_pins (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .pad(pad_bus.pad),
        .sd_cs_n_out(sd_cs_n_out),
        .sd_ras_n_out(sd_ras_n_out),
        .sd_cas_n_out(sd_cas_n_out),
        .sd_we_n_out(sd_we_n_out),
        .sd_a_out(sd_a_out),
        .sd_ba_out(sd_ba_out),
        .sd_dq_in(sd_dq_in),
        .sd_dq_out(sd_dq_out),
        .sd_dq_oe_out(sd_dq_oe_out)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    localparam int COL_AT = RCD + 2;
    localparam int DATA_AT = CAS + 2;
    logic [3:0] pin_cmd;
    assign pin_cmd = {sd_cs_n_out, sd_ras_n_out, sd_cas_n_out, sd_we_n_out};

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_drive8;
        (sd_dq_oe_out == 4'hf) [*8];
    endsequence
    sequence s_deliver8;
        (ad_oe_out) [*8];
    endsequence

    host_phase_gate_a: assert property (
        state == sbs_pkg::SBS_IDLE && !host_clk_in |=> state == sbs_pkg::SBS_IDLE)
        else $error("Burst started outside the first half of a host period.");
    addr_latch_a: assert property (start |=> row == $past(ad_in[20:10])
        && col == $past(ad_in[9:2]) && bank == $past(ad_in[21]))
        else $error("Location not latched from the address phase.");
    row_activate_a: assert property (start |-> ##2 pin_cmd == sbs_pkg::SD_ACTIVATE
        && sd_a_out == $past(ad_in[20:10], 2))
        else $error("Row activate missing two cycles after the address phase.");
    write_cmd_a: assert property (start && host_wr_in |-> ##COL_AT
        ((pin_cmd == sbs_pkg::SD_WRITE && sd_a_out[sbs_pkg::AUTO_CLOSE_BIT]) and s_drive8))
        else $error("Auto-closing write or its eight data beats misplaced.");
    read_cmd_a: assert property (start && !host_wr_in |-> ##COL_AT
        pin_cmd == sbs_pkg::SD_READ && sd_a_out[sbs_pkg::AUTO_CLOSE_BIT])
        else $error("Auto-closing read missing after the row-to-column delay.");
    read_return_a: assert property (pin_cmd == sbs_pkg::SD_READ |-> ##DATA_AT
        s_deliver8 ##1 !ad_oe_out)
        else $error("Eight read words not delivered after the read latency.");
    read_data_a: assert property (ad_oe_out |-> ad_out == $past(sd_dq_in, 2))
        else $error("Host read data does not follow memory data.");
    drive_only_write_a: assert property (sd_dq_oe_out != 4'h0 |->
        $past(state) == sbs_pkg::SBS_WRITE && !ad_oe_out)
        else $error("Memory data driven outside a write burst.");

endmodule : sbs_burst_seq

// File: sbs_sdram_model.sv
/*
 * Behavioural memory model for the burst sequencer bench: it stores one
 * eight-word write burst and returns it on a read after the CAS latency.
 * Assumes the sequencer's registered command pins and one shared clock.
 */
module sbs_sdram_model #(
    parameter int CAS = 2
) (
    input wire logic clk_in,
    input wire logic [3:0] cmd_n_in,
    input wire logic [31:0] dq_in,
    output logic [31:0] dq_out
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [31:0] words [8];
    int wr_beat = 8;
    int rd_beat = 8;
    int rd_wait = 0;

    initial dq_out = 32'h0;

    // Outside a read burst the bus shows the inverse of its last value, so
    // stale data can never be mistaken for a fresh beat.
    always @(posedge clk_in) begin
        if (wr_beat < 8) begin
            words[wr_beat] = dq_in;
            wr_beat++;
        end
        if (rd_beat < 8 && rd_wait <= 1) begin
            dq_out <= words[rd_beat];
            rd_beat++;
        end else begin
            rd_wait--;
            dq_out <= ~dq_out;
        end
        if (cmd_n_in == sbs_pkg::SD_WRITE) begin
            words[0] = dq_in;
            wr_beat = 1;
        end
        if (cmd_n_in == sbs_pkg::SD_READ) begin
            rd_beat = 0;
            rd_wait = CAS - 1;
        end
    end
endmodule : sbs_sdram_model

// File: sbs_burst_seq_tb.sv
/*
 * Self-checking bench for the burst sequencer: write and read bursts over a
 * table of locations, refused address phases and a reset in mid-burst.
 * Assumes the default RCD and CAS of two and the memory model beside it.
 */
module sbs_burst_seq_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic host_clk_in = 1'b0;
    logic data_addr_n_in = 1'b1;
    logic host_wr_in = 1'b0;
    logic [31:0] ad_in = 32'h0;
    logic [31:0] ad_out, sd_dq_in, sd_dq_out;
    logic ad_oe_out, sd_cs_n_out, sd_ras_n_out, sd_cas_n_out, sd_we_n_out, sd_ba_out;
    logic [10:0] sd_a_out;
    logic [3:0] sd_dq_oe_out, cmd_n, exp_c;
    int n_fail = 0;
    int checks = 0;
    logic [31:0] rows [4] = '{32'h0000_0000, 32'h003f_fffc, 32'h0020_0400, 32'h0012_3454};

    assign cmd_n = {sd_cs_n_out, sd_ras_n_out, sd_cas_n_out, sd_we_n_out};
    always #25 core_clk_in = ~core_clk_in;
    always @(negedge core_clk_in) host_clk_in <= ~host_clk_in;

    sbs_burst_seq i_sbs_burst_seq (.core_clk_in, .rst_in, .host_clk_in, .data_addr_n_in,
        .host_wr_in, .ad_in, .ad_out, .ad_oe_out, .sd_cs_n_out, .sd_ras_n_out,
        .sd_cas_n_out, .sd_we_n_out, .sd_a_out, .sd_ba_out, .sd_dq_in, .sd_dq_out,
        .sd_dq_oe_out);

    sbs_sdram_model i_sbs_sdram_model (.clk_in(core_clk_in), .cmd_n_in(cmd_n),
        .dq_in(sd_dq_out), .dq_out(sd_dq_in));

    task automatic chk_cmd(input logic [3:0] got, input logic [3:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_cmd

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic tally_and_finish;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    // Stops at a falling edge after which the host clock takes level hc.
    task automatic align(input logic hc);
        do @(negedge core_clk_in); while (host_clk_in !== ~hc);
    endtask : align

    // One burst; cycle c is what the pins hold as the c-th rising edge after
    // the address phase samples them. For reads, base is the data written earlier.
    task automatic burst(input logic wr, input logic [31:0] a, input logic [31:0] base);
        int c;
        align(1'b1);
        data_addr_n_in = 1'b0;
        host_wr_in = wr;
        ad_in = a;
        for (int k = 1; k <= 17; k++) begin
            @(negedge core_clk_in);
            c = k;
            if (c > 0) begin
                exp_c = (c == 2) ? sbs_pkg::SD_ACTIVATE : (c != 4) ? sbs_pkg::SD_NOP :
                    wr ? sbs_pkg::SD_WRITE : sbs_pkg::SD_READ;
                chk_cmd(cmd_n, exp_c);
                if (c == 2) chk_word({20'h0, sd_ba_out, sd_a_out}, {20'h0, a[21:10]});
                if (c == 4) chk_word({20'h0, sd_ba_out, sd_a_out}, {20'h0, a[21], 3'h4, a[9:2]});
                exp_c = (wr && c >= 4 && c <= 11) ? 4'hf : 4'h0;
                chk_cmd(sd_dq_oe_out, exp_c);
                if (exp_c[0]) chk_word(sd_dq_out, base + c - 4);
                chk_cmd({3'h0, ad_oe_out}, {3'h0, !wr && c >= 8 && c <= 15});
                if (!wr && c >= 8 && c <= 15) chk_word(ad_out, base + c - 8);
            end
            data_addr_n_in = 1'b1;
            // A released bus toggles every cycle rather than holding old data.
            ad_in = (wr && k <= 8) ? base + k - 1 : ~ad_in;
        end
    endtask : burst

    // Address phase that must be ignored: wrong code or host clock low.
    task automatic refused(input logic [1:0] code, input logic hc);
        align(hc);
        data_addr_n_in = 1'b0;
        host_wr_in = 1'b1;
        ad_in = {2'h0, code, 28'h0012345};
        @(negedge core_clk_in);
        data_addr_n_in = 1'b1;
        repeat (8) begin
            @(negedge core_clk_in);
            chk_cmd(cmd_n, sbs_pkg::SD_NOP);
            chk_cmd(sd_dq_oe_out, 4'h0);
        end
    endtask : refused

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        repeat (16) @(negedge core_clk_in);
        chk_cmd(cmd_n, sbs_pkg::SD_DESELECT);
        chk_cmd(sd_dq_oe_out, 4'h0);
        chk_cmd({3'h0, ad_oe_out}, 4'h0);
        rst_in = 1'b0;
        for (int r = 0; r < 4; r++) begin
            burst(1'b1, rows[r], ~rows[r]);
            burst(1'b0, rows[r], ~rows[r]);
        end
        for (int c = 1; c < 4; c++) refused(c[1:0], 1'b1);
        refused(2'h0, 1'b0);
        align(1'b1);
        data_addr_n_in = 1'b0;
        ad_in = rows[1];
        @(negedge core_clk_in);
        data_addr_n_in = 1'b1;
        repeat (2) @(negedge core_clk_in);
        rst_in = 1'b1;
        @(negedge core_clk_in);
        chk_cmd(cmd_n, sbs_pkg::SD_DESELECT);
        chk_cmd(sd_dq_oe_out, 4'h0);
        rst_in = 1'b0;
        burst(1'b1, rows[2], 32'h0bad_f00d);
        burst(1'b0, rows[2], 32'h0bad_f00d);
        tally_and_finish();
    end

    // The whole run takes well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge core_clk_in);
        n_fail++;
        tally_and_finish();
    end
endmodule : sbs_burst_seq_tb
